// ==== include/halt_pkg.sv ====
// constants and types for the halt power mode controller
`default_nettype none
package halt_pkg;
  localparam logic [7:0] HALT_OPCODE = 8'h8E;
  localparam logic [1:0] LEVEL_ENABLED = 2'h2;
  localparam logic [1:0] LEVEL_RESET = 2'h3;
  localparam int STABILIZE_SHORT_CYCLES = 256;
  localparam int STABILIZE_LONG_CYCLES = 4096;
  localparam int WAIT_W = 13;
  typedef enum logic [2:0] {
    ST_RUN        = 3'h0,
    ST_TIMED_STOP = 3'h1,
    ST_STABILIZE  = 3'h3,
    ST_GUARD      = 3'h2,
    ST_FULL_STOP  = 3'h6
  } mode_t;
endpackage
`default_nettype wire

// ==== logic/halt_power_mode_control.sv ====
// halt power mode controller: timed stop, full stop, wake and stabilization
// Overview of operation
// - halt with osc_irq_enable set enters timed stop
// - halt with osc_irq_enable clear enters full stop
// - timed stop exits only on reset or timebase
// - timebase wake from timed stop skips stabilization
// - reset in timed stop waits stabilization first
// - stop entry forces levels 10b; pending wakes, in timed stop only the timebase
// - timed stop keeps oscillator and timebase only
// - timed stop suppresses watchdog reset when enabled
// - early osc_irq_enable clear falls to full stop
// - full stop wake restarts oscillator then waits
// - full stop turns oscillator and peripherals off
// - watchdog_stop_option decides watchdog in full stop
// - service pushes condition_code_reg, loads level, restores
// - opcode 0x8E decodes as halt
`default_nettype none
module halt_power_mode_control #(
  parameter int STABILIZE_SHORT = halt_pkg::STABILIZE_SHORT_CYCLES,
  parameter int STABILIZE_LONG  = halt_pkg::STABILIZE_LONG_CYCLES
) (
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  input  wire logic       clock_enable_in,
  input  wire logic       opcode_valid_in,
  input  wire logic [7:0] opcode_in,
  input  wire logic       osc_irq_enable_in,
  input  wire logic       long_wait_option_in,
  input  wire logic       watchdog_stop_option_in,
  input  wire logic       watchdog_enabled_in,
  input  wire logic       timebase_irq_in,
  input  wire logic       halt_wake_irq_in,
  input  wire logic       any_irq_pending_in,
  input  wire logic       soft_reset_in,
  input  wire logic       irq_service_in,
  input  wire logic [1:0] irq_level_in,
  input  wire logic       cc_pop_in,
  input  wire logic [1:0] cc_pop_level_in,
  output logic [1:0]      cc_level_out,
  output logic [1:0]      cc_push_level_out,
  output logic            cc_push_out,
  output logic            cpu_clock_on_out,
  output logic            periph_clock_on_out,
  output logic            oscillator_on_out,
  output logic            timebase_clock_on_out,
  output logic            watchdog_reset_out,
  output logic            irq_service_allow_out,
  output logic            fetch_reset_vector_out,
  output logic [2:0]      mode_out
);
  logic sync_a;
  logic rst_n;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_a <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      sync_a <= 1'b1;
      rst_n  <= sync_a;
    end
  end

  // the pin clears the flops at once, but release is taken through two
  // flops so that every state flop leaves reset on the same clock edge

  // state of the sequencer and its shared wait counter
  halt_pkg::mode_t mode;
  halt_pkg::mode_t next_mode;
  logic [halt_pkg::WAIT_W-1:0] wait_count;
  logic [halt_pkg::WAIT_W-1:0] next_wait_count;
  logic [1:0] cc_level;
  logic [1:0] next_cc_level;
  // remembers that a reset, not an interrupt, ended the sleep
  logic reset_pend;
  logic next_reset_pend;
  logic wdg_reset;
  logic next_wdg_reset;
  logic [halt_pkg::WAIT_W-1:0] wait_len;
  logic halt_exec;

  // one decoded opcode byte; a stray data byte of the same value does not halt unless opcode_valid_in is high
  assign halt_exec = opcode_valid_in && (opcode_in == halt_pkg::HALT_OPCODE);
  // stabilize and guard both last wait_len + 1 cycles, which gives the
  // option-selected length without a second counter
  assign wait_len = long_wait_option_in ? halt_pkg::WAIT_W'(STABILIZE_LONG - 1)
                                        : halt_pkg::WAIT_W'(STABILIZE_SHORT - 1);

  // next-state logic for mode, counter, levels and flags
  always_comb begin
    next_mode       = mode;
    next_wait_count = wait_count;
    next_cc_level   = cc_level;
    next_reset_pend = reset_pend;
    next_wdg_reset  = 1'b0;
    case (mode)
      halt_pkg::ST_RUN: begin
        // service loads the routine level, a pop restores the stacked one
        if (irq_service_in) begin
          next_cc_level = irq_level_in;
        end else if (cc_pop_in) begin
          next_cc_level = cc_pop_level_in;
        end
        if (halt_exec) begin
          // levels open on every stop entry, whatever the routine had set
          next_cc_level = halt_pkg::LEVEL_ENABLED;
          if (osc_irq_enable_in) begin
            next_mode = halt_pkg::ST_TIMED_STOP;
          end else begin
            next_mode = halt_pkg::ST_FULL_STOP;
            // watchdog not allowed through full stop resets the part
            if (watchdog_enabled_in && !watchdog_stop_option_in) begin
              next_wdg_reset = 1'b1;
            end
          end
          // opening the levels lets a pending request in at once; in timed
          // stop only the timebase may do that, other requests keep waiting
          if (any_irq_pending_in && !(osc_irq_enable_in && !timebase_irq_in)) begin
            next_mode = osc_irq_enable_in ? halt_pkg::ST_GUARD : halt_pkg::ST_STABILIZE;
            next_wait_count = osc_irq_enable_in ? wait_len : '0;
          end
        end
      end

      halt_pkg::ST_TIMED_STOP: begin
        // reset wins when it meets the timebase in the same cycle
        if (soft_reset_in) begin
          next_mode       = halt_pkg::ST_STABILIZE;
          next_reset_pend = 1'b1;
          next_wait_count = '0;
        end else if (timebase_irq_in) begin
          // no stabilize wait: the oscillator never stopped
          next_mode       = halt_pkg::ST_GUARD;
          next_wait_count = wait_len;
        end
      end
      halt_pkg::ST_GUARD: begin
        // cpu runs; osc_irq_enable must hold until the window ends
        // a clear here drops to full stop, which then waits for a wake
        if (!osc_irq_enable_in) begin
          next_mode = halt_pkg::ST_FULL_STOP;
        end else if (wait_count == '0) begin
          next_mode = halt_pkg::ST_RUN;
        end else begin
          next_wait_count = wait_count - 1'b1;
        end
        // interrupts run in the window, so levels follow service and pop
        if (irq_service_in) begin
          next_cc_level = irq_level_in;
        end else if (cc_pop_in) begin
          next_cc_level = cc_pop_level_in;
        end
      end

      halt_pkg::ST_FULL_STOP: begin
        // oscillator is off, so every wake pays the whole stabilize wait
        if (soft_reset_in || halt_wake_irq_in) begin
          next_mode       = halt_pkg::ST_STABILIZE;
          next_reset_pend = soft_reset_in;
          next_wait_count = '0;
        end
      end

      halt_pkg::ST_STABILIZE: begin
        // requests met here stay pending; a reset before the last cycle still ends in a fetch
        if (soft_reset_in) begin
          next_reset_pend = 1'b1;
        end
        if (wait_count == wait_len) begin
          next_mode       = halt_pkg::ST_RUN;
          next_reset_pend = 1'b0;
        end else begin
          next_wait_count = wait_count + 1'b1;
        end
      end

      default: begin
        // unused codes fall back to run rather than lock up
        next_mode = halt_pkg::ST_RUN;
      end
    endcase
  end

  // all state holds still while clock_enable_in is low
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      mode       <= halt_pkg::ST_RUN;
      wait_count <= '0;
      cc_level   <= halt_pkg::LEVEL_RESET;
      reset_pend <= 1'b0;
      wdg_reset  <= 1'b0;
    end else if (clock_enable_in) begin
      mode       <= next_mode;
      wait_count <= next_wait_count;
      cc_level   <= next_cc_level;
      reset_pend <= next_reset_pend;
      wdg_reset  <= next_wdg_reset;
    end
  end

  // clock gates decode straight from the state register, so they switch
  // on the same edge as the mode and never glitch on input changes
  logic stopped;
  assign stopped = (mode == halt_pkg::ST_TIMED_STOP) || (mode == halt_pkg::ST_FULL_STOP) ||
                   (mode == halt_pkg::ST_STABILIZE);

  assign cc_level_out           = cc_level;
  assign cc_push_level_out      = cc_level;
  // push is only asked for while the cpu runs
  assign cc_push_out            = irq_service_in && !stopped;
  assign cpu_clock_on_out       = !stopped;
  assign periph_clock_on_out    = !stopped;
  // oscillator stops only in full stop; stabilize needs it running
  assign oscillator_on_out      = (mode != halt_pkg::ST_FULL_STOP);
  // timebase runs through run, timed stop and the guard window
  assign timebase_clock_on_out  = (mode != halt_pkg::ST_FULL_STOP) && (mode != halt_pkg::ST_STABILIZE);
  // pulse only; the watchdog itself owns the reset that follows
  assign watchdog_reset_out     = wdg_reset;
  assign irq_service_allow_out  = !stopped;
  // fetch is asked for on the last stabilize cycle only
  assign fetch_reset_vector_out = (mode == halt_pkg::ST_STABILIZE) && reset_pend && (wait_count == wait_len);
  assign mode_out               = mode;
endmodule // halt_power_mode_control
`default_nettype wire

// ==== bench/halt_power_mode_control_assertions.sv ====
// port-level checks for the halt power mode controller
`default_nettype none
module halt_checks #(parameter int STABILIZE_SHORT = 256) (
  input wire logic clock_in, reset_n_in, clock_enable_in, opcode_valid_in, osc_irq_enable_in,
  input wire logic long_wait_option_in, watchdog_stop_option_in, watchdog_enabled_in, timebase_irq_in,
  input wire logic halt_wake_irq_in, any_irq_pending_in, soft_reset_in, irq_service_in,
  input wire logic [7:0] opcode_in,
  input wire logic [1:0] irq_level_in, cc_level_out,
  input wire logic cc_push_out, cpu_clock_on_out, periph_clock_on_out, oscillator_on_out,
  input wire logic timebase_clock_on_out, watchdog_reset_out, irq_service_allow_out, fetch_reset_vector_out,
  input wire logic [2:0] mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  int stab_n;
  always_ff @(posedge clock_in or negedge reset_n_in)
    if (!reset_n_in) stab_n <= 0;
    else stab_n <= (mode_out == 3'h3) ? stab_n + 1 : 0;
  sequence halt_s;
    clock_enable_in && mode_out == 3'h0 && opcode_valid_in && opcode_in == halt_pkg::HALT_OPCODE;
  endsequence
  AST_TIMED_ENTRY: assert property (halt_s ##0 osc_irq_enable_in && !timebase_irq_in |=>
    mode_out == 3'h1 && cc_level_out == halt_pkg::LEVEL_ENABLED) else $error("bad timed stop entry");
  AST_FULL_ENTRY: assert property (halt_s ##0 !osc_irq_enable_in && !any_irq_pending_in |=>
    mode_out == 3'h6 && cc_level_out == halt_pkg::LEVEL_ENABLED) else $error("bad full stop entry");
  AST_TIMED_HOLD: assert property (mode_out == 3'h1 && !timebase_irq_in && !soft_reset_in |=>
    mode_out == 3'h1) else $error("timed stop left without cause");
  AST_TB_WAKE: assert property (mode_out == 3'h1 && timebase_irq_in && !soft_reset_in |=>
    mode_out == 3'h2 && cpu_clock_on_out) else $error("timebase wake not immediate");
  AST_TIMED_CLOCKS: assert property (mode_out == 3'h1 |-> oscillator_on_out && timebase_clock_on_out
    && !cpu_clock_on_out && !periph_clock_on_out && !watchdog_reset_out) else $error("timed stop clocks");
  AST_FULL_OFF: assert property (mode_out == 3'h6 |->
    !oscillator_on_out && !cpu_clock_on_out && !periph_clock_on_out) else $error("full stop clocks");
  AST_FULL_WAKE: assert property (mode_out == 3'h6 && halt_wake_irq_in |=>
    mode_out == 3'h3 && oscillator_on_out && !irq_service_allow_out) else $error("full stop wake");
  AST_STAB_LEN: assert property ($fell(mode_out == 3'h3) && !long_wait_option_in |->
    stab_n == STABILIZE_SHORT) else $error("stabilize length wrong");
  AST_WDOG_HALT: assert property (halt_s ##0 !osc_irq_enable_in && watchdog_enabled_in
    && !watchdog_stop_option_in |-> ##[1:2] watchdog_reset_out) else $error("no watchdog reset");
  AST_RESET_WAKE: assert property (mode_out == 3'h1 && soft_reset_in |=> mode_out == 3'h3)
    else $error("reset wake skipped stabilize");
  AST_FETCH: assert property (fetch_reset_vector_out |-> mode_out == 3'h3 ##1 mode_out == 3'h0)
    else $error("fetch pulse misplaced");
  AST_PENDING_WAKE: assert property (halt_s ##0 !osc_irq_enable_in && any_irq_pending_in |=>
    mode_out == 3'h3) else $error("pending request did not wake");
  AST_WDOG_ALLOWED: assert property (halt_s ##0 !osc_irq_enable_in && watchdog_stop_option_in |=>
    !watchdog_reset_out) else $error("watchdog reset despite option");
  AST_SERVICE: assert property (irq_service_in && mode_out == 3'h0 |-> cc_push_out
    ##1 cc_level_out == $past(irq_level_in)) else $error("service level not loaded");
endmodule // halt_checks
`default_nettype wire

// ==== bench/timebase_partner.sv ====
// timebase model: raises its interrupt after a fixed span of timed stop
`default_nettype none
module timebase_partner #(parameter int PERIOD = 5) (
  input  wire logic clock_in, reset_n_in, timebase_clock_on_out, cpu_clock_on_out,
  output logic      timebase_irq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int n;
  // ticks only while its clock runs and the cpu sleeps; drops once the cpu wakes
  always_ff @(posedge clock_in or negedge reset_n_in)
    if (!reset_n_in) n <= 0;
    else n <= (timebase_clock_on_out && !cpu_clock_on_out) ? n + 1 : 0;
  assign timebase_irq_in = (n >= PERIOD);
endmodule // timebase_partner
`default_nettype wire

// ==== bench/test_halt_power_mode_control.sv ====
// self-checking bench for the halt power mode controller
`default_nettype none
module test_halt_power_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 0, reset_n_in = 0, clock_enable_in = 1, opcode_valid_in = 0, osc_irq_enable_in = 0;
  logic long_wait_option_in = 0, watchdog_stop_option_in = 0, watchdog_enabled_in = 1, timebase_irq_in;
  logic halt_wake_irq_in = 0, any_irq_pending_in = 0, soft_reset_in = 0, irq_service_in = 0, cc_pop_in = 0;
  logic [7:0] opcode_in = 8'h00;
  logic [1:0] irq_level_in = 2'h1, cc_pop_level_in = 2'h3, cc_level_out, cc_push_level_out;
  logic cc_push_out, cpu_clock_on_out, periph_clock_on_out, oscillator_on_out, timebase_clock_on_out;
  logic watchdog_reset_out, irq_service_allow_out, fetch_reset_vector_out;
  logic [2:0] mode_out;
  int err_total = 0, n_checks = 0, k;
  halt_power_mode_control #(.STABILIZE_SHORT(8), .STABILIZE_LONG(16)) dut (.*);
  timebase_partner #(.PERIOD(5)) tbm (.*);
  initial forever #4 clock_in = ~clock_in;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic exec(input logic [7:0] op, input logic osc_irq_enable);
    step(1);
    osc_irq_enable_in = osc_irq_enable;
    opcode_in = op;
    opcode_valid_in = 1;
    step(1);
    opcode_valid_in = 0;
  endtask
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 40 && mode_out !== m; i++) step(1);
    chk("mode", m, mode_out);
  endtask
  task automatic t_service;
    clock_enable_in = 0;
    exec(halt_pkg::HALT_OPCODE, 0);
    chk("frozen mode", 0, mode_out);
    chk("frozen wdg", 0, watchdog_reset_out);
    clock_enable_in = 1;
    irq_service_in = 1;
    step(0);
    #1 chk("push", 1, cc_push_out);
    chk("push level", 3, cc_push_level_out);
    step(1);
    irq_service_in = 0;
    chk("level", 1, cc_level_out);
    cc_pop_in = 1;
    step(1);
    cc_pop_in = 0;
    chk("level", 3, cc_level_out);
    exec(8'h8F, 0);
    chk("mode", 0, mode_out);
  endtask
  task automatic t_timed;
    exec(halt_pkg::HALT_OPCODE, 1);
    chk("mode", 1, mode_out);
    chk("level", 2, cc_level_out);
    chk("clocks", 3'h1, {cpu_clock_on_out, periph_clock_on_out, oscillator_on_out});
    chk("tb clock", 1, timebase_clock_on_out);
    chk("wdg", 0, watchdog_reset_out);
    halt_wake_irq_in = 1;
    step(2);
    halt_wake_irq_in = 0;
    chk("mode", 1, mode_out);
    wait_mode(2);
    step(10);
    chk("mode", 0, mode_out);
  endtask
  task automatic t_early;
    exec(halt_pkg::HALT_OPCODE, 1);
    wait_mode(2);
    osc_irq_enable_in = 0;
    step(2);
    chk("mode", 6, mode_out);
    halt_wake_irq_in = 1;
    step(1);
    halt_wake_irq_in = 0;
    wait_mode(0);
  endtask
  task automatic t_full;
    exec(halt_pkg::HALT_OPCODE, 0);
    chk("mode", 6, mode_out);
    chk("osc", 0, oscillator_on_out);
    chk("wdg", 1, watchdog_reset_out);
    halt_wake_irq_in = 1;
    step(1);
    halt_wake_irq_in = 0;
    chk("mode", 3, mode_out);
    chk("allow", 0, irq_service_allow_out);
    wait_mode(0);
  endtask
  task automatic t_reset;
    exec(halt_pkg::HALT_OPCODE, 1);
    soft_reset_in = 1;
    step(1);
    soft_reset_in = 0;
    chk("mode", 3, mode_out);
    k = 0;
    repeat (12) begin
      k += fetch_reset_vector_out;
      step(1);
    end
    chk("fetch", 1, 3'(k));
    chk("mode", 0, mode_out);
  endtask
  task automatic t_pending;
    any_irq_pending_in = 1;
    watchdog_stop_option_in = 1;
    long_wait_option_in = 1;
    exec(halt_pkg::HALT_OPCODE, 0);
    any_irq_pending_in = 0;
    chk("mode", 3, mode_out);
    chk("wdg", 0, watchdog_reset_out);
    k = 0;
    while (mode_out === 3'h3 && k < 40) begin
      k++;
      step(1);
    end
    chk("stab len", 16, 8'(k));
    chk("mode", 0, mode_out);
    long_wait_option_in = 0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    step(20);
    reset_n_in = 1;
    step(3);
    t_service();
    t_timed();
    t_early();
    t_full();
    t_reset();
    t_pending();
    report_and_stop();
  end
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end
endmodule // test_halt_power_mode_control
bind halt_power_mode_control halt_checks #(.STABILIZE_SHORT(STABILIZE_SHORT)) checks (.*);
`default_nettype wire
